// [hw/vdc_pkg.sv]
// Package for the oscillator divider control block: register map, fields, resets.
// Assumes an Avalon-MM slave with 32-bit data and one register per aligned word.
`default_nettype none

package vdc_pkg;

  // ----------------------------------------------------------------
  // Register indices and bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W         = 12;
  localparam logic [11:0] IDX_CONTROL    = 12'h120;
  localparam logic [11:0] IDX_RATIOS     = 12'h121;
  localparam logic [11:0] IDX_MASK       = 12'h122;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTL_SYNC1      = 6;
  localparam int unsigned CTL_PD1        = 5;
  localparam int unsigned CTL_RST1       = 4;
  localparam int unsigned CTL_SYNC0      = 2;
  localparam int unsigned CTL_PD0        = 1;
  localparam int unsigned CTL_RST0       = 0;
  localparam int unsigned RAT1_LSB       = 4;
  localparam int unsigned RAT0_LSB       = 0;
  localparam int unsigned NUM_OUT        = 5;

  // ----------------------------------------------------------------
  // Writable bits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CONTROL_WMASK  = 8'h77;
  localparam logic [7:0]  CONTROL_RESET  = 8'h20;
  localparam logic [7:0]  RATIOS_RESET   = 8'h44;
  localparam logic [7:0]  MASK_WMASK     = 8'h7F;
  localparam logic [7:0]  MASK_RESET     = 8'h00;
  localparam logic [3:0]  RATIO_MIN      = 4'h2;
  localparam logic [3:0]  RATIO_MAX      = 4'hB;

  // ----------------------------------------------------------------
  // Per-divider control bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       power_down;
    logic       reset;
    logic [3:0] ratio;
  } vdc_div_ctl_t;

endpackage : vdc_pkg

`default_nettype wire

// [hw/vdc_divider_decode.sv]
// One oscillator divider's control decode: effective power-down, reset and ratio.
// Assumes register fields arrive straight from the register file.
`default_nettype none

module vdc_divider_decode
  import vdc_pkg::*;
(
  // Register fields
  input  wire logic       pd_bit_i,
  input  wire logic       rst_bit_i,
  input  wire logic [3:0] ratio_i,
  // Decoded control
  output vdc_div_ctl_t    ctl_o
);

  wire ratio_ok = (ratio_i >= RATIO_MIN) && (ratio_i <= RATIO_MAX);

  assign ctl_o.power_down = pd_bit_i | ~ratio_ok;
  assign ctl_o.reset      = rst_bit_i;
  assign ctl_o.ratio      = ratio_i;

endmodule : vdc_divider_decode

`default_nettype wire

// [hw/vdc_top.sv]
// Oscillator divider control: two dividers, sync commands and sync masks.
// Assumes an Avalon-MM master on ref_clk_i; downstream dividers sample levels.
//
// Chosen here: the Avalon-MM interface to the registers.
`default_nettype none

module vdc_top
  import vdc_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // Divider controls
  output vdc_div_ctl_t           first_vco_divider_o,
  output vdc_div_ctl_t           second_vco_divider_o,
  // Downstream sync resets: [4] fixed delay feedback, [3:0] outputs three..zero
  output logic [NUM_OUT-1:0]     out_sync_reset_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] vco_divider_control;
  logic [7:0] vco_divider_ratios;
  logic [7:0] sync_mask_select;
  logic       ack;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if ((NUM_OUT != 5) || (RATIO_MIN > RATIO_MAX))
  begin : g_bad_config
    $error("Sync fan-out must be five lines with an ordered ratio range");
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit
  (
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] idx
  );
    reg_hit = (addr == idx);
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // Sync hold decode
  // ----------------------------------------------------------------
  // A sync line holds its destinations unless they ignore it
  function automatic logic [NUM_OUT-1:0] sync_hold
  (
    input logic               sync,
    input logic [NUM_OUT-1:0] reach,
    input logic [NUM_OUT-1:0] ignore
  );
    sync_hold = {NUM_OUT{sync}} & reach & ~ignore;
  endfunction : sync_hold

  wire req       = avs_read_i | avs_write_i;
  wire sel_ctl   = reg_hit(avs_address_i, IDX_CONTROL);
  wire sel_rat   = reg_hit(avs_address_i, IDX_RATIOS);
  wire sel_msk   = reg_hit(avs_address_i, IDX_MASK);

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  wire wr_take   = avs_write_i & ack & avs_byteenable_i[0];
  wire wr_ctl    = wr_take & sel_ctl;
  wire wr_rat    = wr_take & sel_rat;
  wire wr_msk    = wr_take & sel_msk;
  wire rd_load   = avs_read_i & ~ack;

  wire [7:0] next_control = avs_writedata_i[7:0] & CONTROL_WMASK;
  wire [7:0] next_ratios  = avs_writedata_i[7:0];
  wire [7:0] next_mask    = avs_writedata_i[7:0] & MASK_WMASK;

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  wire [7:0] rd_byte = sel_ctl ? vco_divider_control :
                       sel_rat ? vco_divider_ratios  :
                       sel_msk ? sync_mask_select    : 8'h00;
  wire [31:0] next_readdata = {24'h00_0000, rd_byte};

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle, then the answer
  assign avs_waitrequest_o = req & ~ack;

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= req & ~ack;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      vco_divider_control <= CONTROL_RESET;
    end
    else if (wr_ctl)
    begin
      vco_divider_control <= next_control;
    end
  end

  // ----------------------------------------------------------------
  // Ratio register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      vco_divider_ratios <= RATIOS_RESET;
    end
    else if (wr_rat)
    begin
      vco_divider_ratios <= next_ratios;
    end
  end

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync_mask_select <= MASK_RESET;
    end
    else if (wr_msk)
    begin
      sync_mask_select <= next_mask;
    end
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      avs_readdata_o <= 32'h0000_0000;
    end
    else if (rd_load)
    begin
      avs_readdata_o <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // Divider decode
  // ----------------------------------------------------------------
  wire       first_pd_bit   = vco_divider_control[CTL_PD0];
  wire       first_rst_bit  = vco_divider_control[CTL_RST0];
  wire [3:0] first_ratio    = vco_divider_ratios[RAT0_LSB +: 4];
  wire       second_pd_bit  = vco_divider_control[CTL_PD1];
  wire       second_rst_bit = vco_divider_control[CTL_RST1];
  wire [3:0] second_ratio   = vco_divider_ratios[RAT1_LSB +: 4];

  vdc_divider_decode u_first
  (
    .pd_bit_i  (first_pd_bit),
    .rst_bit_i (first_rst_bit),
    .ratio_i   (first_ratio),
    .ctl_o     (first_vco_divider_o)
  );

  vdc_divider_decode u_second
  (
    .pd_bit_i  (second_pd_bit),
    .rst_bit_i (second_rst_bit),
    .ratio_i   (second_ratio),
    .ctl_o     (second_vco_divider_o)
  );

  // ----------------------------------------------------------------
  // Sync distribution
  // ----------------------------------------------------------------
  wire first_divider_sync_bit  = vco_divider_control[CTL_SYNC0];
  wire second_divider_sync_bit = vco_divider_control[CTL_SYNC1];
  // Second divider reaches outputs one and two via mask bits 5 and 6
  wire [NUM_OUT-1:0] second_reach = 5'h06;
  wire [NUM_OUT-1:0] first_reach  = {NUM_OUT{1'b1}};
  wire [NUM_OUT-1:0] second_mask  = {2'b00, sync_mask_select[6:5], 1'b0};
  wire [NUM_OUT-1:0] first_mask   = sync_mask_select[4:0];
  wire [NUM_OUT-1:0] first_hold   =
    sync_hold(first_divider_sync_bit, first_reach, first_mask);
  wire [NUM_OUT-1:0] second_hold  =
    sync_hold(second_divider_sync_bit, second_reach, second_mask);

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_sync
      assign out_sync_reset_o[g] = first_hold[g] | second_hold[g];
    end
  endgenerate

endmodule : vdc_top

`default_nettype wire

// [test/vdc_top_asserts.sv]
// Checker for the divider control block; shadows written registers.
// Assumes it is bound into vdc_top and sees only its ports.
`default_nettype none
module vdc_top_asserts
  import vdc_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              nrst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic              avs_write_i,
  input wire logic [31:0]       avs_writedata_i,
  input wire logic [3:0]        avs_byteenable_i,
  input wire logic              avs_waitrequest_o,
  input wire vdc_div_ctl_t      first_vco_divider_o,
  input wire vdc_div_ctl_t      second_vco_divider_o,
  input wire logic [NUM_OUT-1:0] out_sync_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c;
  logic [7:0] m;
  logic [7:0] r;
  wire        wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  always_ff @(posedge ref_clk_i or negedge nrst_i)
    if (!nrst_i) {c, r, m} <= 24'h204400;
    else if (wr_ok && avs_address_i == IDX_CONTROL) c <= avs_writedata_i[7:0] & CONTROL_WMASK;
    else if (wr_ok && avs_address_i == IDX_RATIOS) r <= avs_writedata_i[7:0];
    else if (wr_ok && avs_address_i == IDX_MASK) m <= avs_writedata_i[7:0] & MASK_WMASK;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_SYNC: assert property ($rose(c[2]) && m[4:0] == 5'h00 |-> &out_sync_reset_o)
    else $error("first sync did not reset outputs");
  AST_IDLE: assert property (!c[2] && !c[6] |-> out_sync_reset_o == 5'h00)
    else $error("sync output without sync bit");
  AST_RST: assert property (first_vco_divider_o.reset == c[0] && second_vco_divider_o.reset == c[4])
    else $error("divider reset wrong");
  AST_RAT1: assert property (second_vco_divider_o.ratio == r[7:4] &&
      second_vco_divider_o.power_down == (c[5] || !(r[7:4] inside {[4'h2:4'hB]})))
    else $error("second power down wrong");
  AST_RAT0: assert property (first_vco_divider_o.ratio == r[3:0] &&
      first_vco_divider_o.power_down == (c[1] || !(r[3:0] inside {[4'h2:4'hB]})))
    else $error("first power down wrong");
  AST_MSK1: assert property (out_sync_reset_o[2:1] == (({2{c[2]}} & ~m[2:1]) | ({2{c[6]}} & ~m[6:5])))
    else $error("second sync mask wrong");
  AST_MSK0: assert property ({out_sync_reset_o[4:3], out_sync_reset_o[0]} == ({3{c[2]}} & ~{m[4:3], m[0]}))
    else $error("first sync mask wrong");
endmodule : vdc_top_asserts
bind vdc_top vdc_top_asserts u_asserts (.*);
`default_nettype wire

// [test/vdc_dn_model.sv]
// Downstream divider model: a divider sits in reset while its sync line is high.
// Assumes sync lines are levels from the control block.
`default_nettype none
module vdc_dn_model (
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [4:0] sync_reset_i,
  output logic      [4:0] held_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge ref_clk_i or negedge nrst_i)
    if (!nrst_i) held_o <= 5'h00;
    else held_o <= sync_reset_i;
endmodule : vdc_dn_model
`default_nettype wire

// [test/vdc_top_tb.sv]
// Self-checking bench for the divider control block.
// Assumes the package, top and downstream model are compiled first.
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module vdc_top_tb
  import vdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
  logic [11:0] avs_address_i = 12'h000;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [4:0]  out_sync_reset_o, held, e;
  logic [7:0]  m;
  vdc_div_ctl_t first_vco_divider_o, second_vco_divider_o;
  int mismatches, total_checks, cyc;
  vdc_top u_dut (.*);
  vdc_dn_model u_dn (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sync_reset_i(out_sync_reset_o), .held_o(held));
  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (++cyc == 3000) begin mismatches++; results(); end
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_read_i <= !w;
    avs_write_i <= w;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : acc
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    acc(1'b0, a, 8'h00);
    `CHK("readback", x, q)
  endtask : rdc
  task automatic t_reset;
    rdc(IDX_CONTROL, 32'h20);
    rdc(IDX_RATIOS, 32'h44);
    rdc(IDX_MASK, 32'h0);
    `CHK("pd second", 1'b1, second_vco_divider_o.power_down)
  endtask : t_reset
  task automatic t_ctl;
    acc(1'b1, IDX_CONTROL, 8'hBB);
    rdc(IDX_CONTROL, 32'h33);
    `CHK("ctl out", 6'h34, {first_vco_divider_o.power_down, first_vco_divider_o.reset, second_vco_divider_o.ratio})
    `CHK("rst second", 1'b1, second_vco_divider_o.reset)
    `CHK("pd second set", 1'b1, second_vco_divider_o.power_down)
    acc(1'b1, IDX_CONTROL, 8'h00);
  endtask : t_ctl
  task automatic t_ratio;
    for (int i = 0; i < 16; i++)
    begin
      acc(1'b1, IDX_RATIOS, {i[3:0], 4'hF - i[3:0]});
      `CHK("ratio second", {!(i inside {[2:11]}), i[3:0]}, {second_vco_divider_o.power_down, second_vco_divider_o.ratio})
      `CHK("ratio first", !((15 - i) inside {[2:11]}), first_vco_divider_o.power_down)
      `CHK("ratio first field", 4'hF - i[3:0], first_vco_divider_o.ratio)
    end
  endtask : t_ratio
  task automatic t_sync;
    for (int j = 0; j < 9; j++)
    begin
      m = (j == 8) ? 8'h00 : 8'h01 << j;
      acc(1'b1, IDX_MASK, m);
      m = m & 8'h7F;
      acc(1'b1, IDX_CONTROL, 8'h04);
      @(posedge ref_clk_i);
      `CHK("held first", ~m[4:0], held)
      acc(1'b1, IDX_CONTROL, 8'h40);
      e = {2'b00, ~m[6:5], 1'b0};
      `CHK("sync second", e, out_sync_reset_o)
      acc(1'b1, IDX_CONTROL, 8'h00);
      `CHK("sync clear", 5'h00, out_sync_reset_o)
    end
  endtask : t_sync
  task automatic t_bus;
    avs_byteenable_i <= 4'h0;
    acc(1'b1, IDX_CONTROL, 8'h77);
    avs_byteenable_i <= 4'hF;
    acc(1'b1, 12'h123, 8'hFF);
    rdc(12'h123, 32'h0);
    rdc(IDX_CONTROL, 32'h0);
  endtask : t_bus
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    t_reset();
    t_ctl();
    t_ratio();
    t_sync();
    t_bus();
    results();
  end
endmodule : vdc_top_tb
`default_nettype wire
